/* rtl/cdsw_pkg.sv */
// Package with the diagnostic word layout, constants and carrier types.
package cdsw_pkg;
  localparam int WORD_W = 16;
  localparam int BIT_CONFIG_INCOMPLETE = 0;
  localparam int BIT_SINGLE_PACKET = 1;
  localparam int BIT_BUS_COMM_ERROR = 2;
  localparam int BIT_NO_MODULE = 3;
  localparam int BIT_SERVICE_ELAPSED = 5;
  localparam int BIT_MODULE_ERROR = 6;
  localparam int BIT_COUPLER_ERROR = 7;
  localparam logic [15:0] RESERVED_MASK = 16'hFF10;
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [15:0] INPUT_REG_DIAG = 16'h07D1;
  localparam logic [7:0] FUNC_READ_INPUT = 8'h04;
  localparam int UNITS_PER_YEAR = 52560;
  localparam int SERVICE_YEARS = 3;
  localparam int SERVICE_LIMIT = UNITS_PER_YEAR * SERVICE_YEARS;
  localparam int HOURS_W = 24;
  localparam logic REPORT_RESET = 1'b0;

  typedef struct packed {
    logic couplerError;
    logic channelError;
    logic fieldPowerError;
    logic busPowerError;
    logic busCommError;
    logic moduleReplaceError;
    logic singlePacket;
    logic configIncomplete;
  } cdsw_cond_t;

  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
  } cdsw_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [15:0] data;
  } cdsw_rsp_t;
endpackage : cdsw_pkg

/* rtl/cdsw_service_timer.sv */
// Operating-time counter that flags the end of the service period.
`timescale 1ns/10ps
module cdsw_service_timer #(
  parameter int LIMIT = cdsw_pkg::SERVICE_LIMIT,
  parameter int CW = cdsw_pkg::HOURS_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic unitTick,
  input wire logic [CW-1:0] presetCount,
  input wire logic presetLoad,
  output logic elapsed
);
  import cdsw_pkg::*;
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
  logic [CW-1:0] count_reg;

  // One step of headroom past the limit is needed for the saturating count.
  if (CW > 30 || LIMIT < 1 || LIMIT >= (1 << CW) - 1) begin : g_bad_limit
    $error("Service limit does not fit counter.");
  end

  // The count saturates just past the limit so it never wraps to zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (presetLoad) begin
      count_reg <= presetCount;
    end else if (unitTick && count_reg <= LIMIT_C) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      elapsed <= 1'b0;
    end else begin
      elapsed <= (count_reg > LIMIT_C);
    end
  end
endmodule : cdsw_service_timer

/* rtl/cdsw_diag_word.sv */
// Coupler diagnostic status word: gathering, storage and read access.
//
// Operation
// - One 16-bit word per coupler; bits 15..8 and 4 reserved.
// - Master sees the word only while reporting is enabled.
// - Configuration port can always read the word.
// - Word refreshes on every cyclic module bus exchange.
// - Interrupt option starts an immediate exchange when an error appears.
// - Bit 7 shows coupler, settings or network error.
// - Bit 6 is OR of channel, field power and bus power errors.
// - Bit 5 sets once operating count exceeds 157,680 units.
// - Bit 3 set when no module is attached.
// - Bit 2 set on module bus comm fault or replacement error.
// - Bit 1 set in single-packet mode, clear in multi-packet.
// - Bit 0 set while module configuration is incomplete.
// - Indicators follow the current diagnostic word.
// - Word is input register 2001, function 04, high byte first, read-only.
// - Reporting disabled after power-up until configured on.
`timescale 1ns/10ps
module cdsw_diag_word #(
  parameter int SERVICE_LIMIT = cdsw_pkg::SERVICE_LIMIT
) (
  sys_clk,
  sys_rst,
  cond,
  moduleCount,
  cycleDone,
  unitTick,
  hoursPreset,
  hoursLoad,
  reportEnable,
  interruptEnable,
  cfgLoad,
  masterReq,
  usbRead,
  masterRsp,
  usbData,
  exchangeStart,
  diagWord,
  couplerLed,
  moduleFaultIndicator
);
  import cdsw_pkg::*;
  input wire logic sys_clk;
  input wire logic sys_rst;
  input wire cdsw_pkg::cdsw_cond_t cond;
  input wire logic [7:0] moduleCount;
  input wire logic cycleDone;
  input wire logic unitTick;
  input wire logic [cdsw_pkg::HOURS_W-1:0] hoursPreset;
  input wire logic hoursLoad;
  input wire logic reportEnable;
  input wire logic interruptEnable;
  input wire logic cfgLoad;
  input wire cdsw_pkg::cdsw_req_t masterReq;
  input wire logic usbRead;
  output cdsw_pkg::cdsw_rsp_t masterRsp;
  output logic [15:0] usbData;
  output logic exchangeStart;
  output logic [15:0] diagWord;
  output logic couplerLed;
  output logic moduleFaultIndicator;

  logic report_reg;
  logic irqOpt_reg;
  logic serviceElapsed;
  logic [15:0] rawFlags;
  logic [15:0] diag_next;
  logic [15:0] word_reg;
  logic [15:0] errBits;
  logic [15:0] errBits_reg;
  logic newError;
  logic diagAsk;

  // Flags that may start an immediate exchange; the service and empty
  // coupler bits are slow conditions and never qualify.
  localparam logic [15:0] IRQ_MASK = (16'h0001 << BIT_COUPLER_ERROR) |
    (16'h0001 << BIT_MODULE_ERROR) | (16'h0001 << BIT_BUS_COMM_ERROR) |
    (16'h0001 << BIT_SINGLE_PACKET) | (16'h0001 << BIT_CONFIG_INCOMPLETE);

  // The operating count must be able to pass the limit without wrapping.
  if (SERVICE_LIMIT < 1 ||
      SERVICE_LIMIT >= (1 << HOURS_W) - 1) begin : g_bad_limit
    $error("Service limit does not fit the operating-time counter.");
  end

  if (WORD_W != 16) begin : g_bad_width
    $error("Diagnostic word must be sixteen bits wide.");
  end

  // No flag in IRQ_MASK may sit on a reserved position.
  if ((IRQ_MASK & RESERVED_MASK) != 16'h0000) begin : g_bad_map
    $error("A live flag overlaps a reserved bit.");
  end

  // The preset lets firmware restore the operating count kept across power
  // cycles; without it the service period would restart at every power-up.
  cdsw_service_timer #(
    .LIMIT(SERVICE_LIMIT),
    .CW(HOURS_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .unitTick(unitTick),
    .presetCount(hoursPreset),
    .presetLoad(hoursLoad),
    .elapsed(serviceElapsed)
  );

  // Configuration options latch on cfgLoad; both start off.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      report_reg <= REPORT_RESET;
    end else if (cfgLoad) begin
      report_reg <= reportEnable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqOpt_reg <= 1'b0;
    end else if (cfgLoad) begin
      irqOpt_reg <= interruptEnable;
    end
  end

  // Every bit is a live level taken from the current conditions; nothing
  // here latches, so a cleared fault clears its bit at the next capture.
  always_comb begin
    rawFlags = DIAG_RESET;
    rawFlags[BIT_COUPLER_ERROR] = cond.couplerError;
    rawFlags[BIT_MODULE_ERROR] = cond.channelError |
      cond.fieldPowerError | cond.busPowerError;
    rawFlags[BIT_SERVICE_ELAPSED] = serviceElapsed;
    rawFlags[BIT_NO_MODULE] = (moduleCount == 8'h00);
    rawFlags[BIT_BUS_COMM_ERROR] = cond.busCommError |
      cond.moduleReplaceError;
    rawFlags[BIT_SINGLE_PACKET] = cond.singlePacket;
    rawFlags[BIT_CONFIG_INCOMPLETE] = cond.configIncomplete;
  end

  // Reserved positions are tied off bit by bit, so a flag mapped onto one
  // by mistake can never reach the master.
  for (genvar b = 0; b < WORD_W; b++) begin : g_bit
    if (RESERVED_MASK[b]) begin : g_reserved
      assign diag_next[b] = 1'b0;
    end else begin : g_live
      assign diag_next[b] = rawFlags[b];
    end
  end

  // The stored word moves only at exchange boundaries so the master never
  // sees a half-updated set of flags between cycles.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      word_reg <= DIAG_RESET;
    end else if (cycleDone) begin
      word_reg <= diag_next;
    end
  end

  assign errBits = diag_next & IRQ_MASK;
  // A flag that rises while another error already stands is still a fresh
  // error, so any rising IRQ_MASK flag starts an exchange; flags rising in the same cycle share one.
  assign newError = |(errBits & ~errBits_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      errBits_reg <= 16'h0000;
    end else begin
      errBits_reg <= errBits;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      exchangeStart <= 1'b0;
    end else begin
      exchangeStart <= irqOpt_reg & newError;
    end
  end

  // The port copy trails the stored word by one cycle so that it comes
  // straight from a flip-flop.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      diagWord <= DIAG_RESET;
    end else begin
      diagWord <= word_reg;
    end
  end

  // Indicators follow the stored word, not the raw conditions, so they
  // never show a state that the master could not read.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      couplerLed <= 1'b0;
      moduleFaultIndicator <= 1'b0;
    end else begin
      couplerLed <= word_reg[BIT_COUPLER_ERROR];
      moduleFaultIndicator <= word_reg[BIT_MODULE_ERROR];
    end
  end

  // Only a read of input register 2001 hits; anything else is left for
  // the rest of the process image, so writes never reach this word.
  assign diagAsk = masterReq.valid && report_reg &&
    masterReq.func == FUNC_READ_INPUT &&
    masterReq.addr == INPUT_REG_DIAG;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      masterRsp <= '0;
    end else begin
      masterRsp.valid <= masterReq.valid;
      masterRsp.hit <= diagAsk;
      masterRsp.data <= diagAsk ? word_reg : 16'h0000;
    end
  end

  // The configuration port reads the word whether or not reporting toward
  // the master is on.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      usbData <= DIAG_RESET;
    end else if (usbRead) begin
      usbData <= word_reg;
    end
  end
endmodule : cdsw_diag_word

/* tb/cdsw_checker.sv */
// Concurrent checks on the diagnostic word block's ports.
`timescale 1ns/10ps
module cdsw_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cdsw_pkg::cdsw_cond_t cond,
  input wire logic [7:0] moduleCount,
  input wire logic cycleDone,
  input wire cdsw_pkg::cdsw_req_t masterReq,
  input wire cdsw_pkg::cdsw_rsp_t masterRsp,
  input wire logic usbRead,
  input wire logic [15:0] usbData,
  input wire logic [15:0] diagWord,
  input wire logic couplerLed,
  input wire logic moduleFaultIndicator
);
  import cdsw_pkg::*;
  wire logic modErr = cond.channelError | cond.fieldPowerError |
    cond.busPowerError;
  wire logic [3:0] lowExp = {moduleCount == 8'h00,
    cond.busCommError | cond.moduleReplaceError, cond.singlePacket,
    cond.configIncomplete};
  wire logic askDiag = masterReq.func == FUNC_READ_INPUT &&
    masterReq.addr == INPUT_REG_DIAG;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reserved_zero: assert property (
    (diagWord & RESERVED_MASK) == 16'h0000) else $error("reserved bit set");
  a_rsp_pulse: assert property (
    masterRsp.valid == $past(masterReq.valid)) else $error("reply timing");
  a_refuse_other: assert property (
    masterReq.valid && !askDiag |=> !masterRsp.hit &&
    masterRsp.data == 16'h0000) else $error("foreign access answered");
  a_coupler_bit: assert property (
    cycleDone |-> ##2 diagWord[7] == $past(cond.couplerError, 2))
    else $error("coupler bit wrong");
  a_module_bit: assert property (
    cycleDone |-> ##2 diagWord[6] == $past(modErr, 2))
    else $error("module bit wrong");
  a_low_bits: assert property (
    cycleDone |-> ##2 diagWord[3:0] == $past(lowExp, 2))
    else $error("low flags wrong");
  a_usb_copy: assert property (
    usbRead |=> usbData == diagWord) else $error("usb copy wrong");
  a_hit_valid: assert property (
    masterRsp.hit |-> masterRsp.valid) else $error("hit without reply");
  a_led_copy: assert property (
    couplerLed == diagWord[7] && moduleFaultIndicator == diagWord[6])
    else $error("indicator mismatch");
endmodule : cdsw_checker
bind cdsw_diag_word cdsw_checker u_cdsw_checker (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .cond(cond),
  .moduleCount(moduleCount),
  .cycleDone(cycleDone),
  .masterReq(masterReq),
  .masterRsp(masterRsp),
  .usbRead(usbRead),
  .usbData(usbData),
  .diagWord(diagWord),
  .couplerLed(couplerLed),
  .moduleFaultIndicator(moduleFaultIndicator)
);

/* tb/cdsw_master_model.sv */
// Field-network master model that issues register reads.
`timescale 1ns/10ps
module cdsw_master_model (
  input wire logic sys_clk,
  output cdsw_pkg::cdsw_req_t masterReq,
  input wire cdsw_pkg::cdsw_rsp_t masterRsp
);
  import cdsw_pkg::*;
  initial masterReq = '0;
  // A released request carries inverted fields, so stale ones never match.
  task read(input logic [7:0] f, input logic [15:0] a, output logic h,
    output logic [15:0] d);
    @(posedge sys_clk) masterReq <= '{1'b1, f, a};
    @(posedge sys_clk) masterReq <= '{1'b0, ~f, ~a};
    #1;
    h = masterRsp.valid & masterRsp.hit;
    d = {masterRsp.data[15:8], masterRsp.data[7:0]};
  endtask : read
endmodule : cdsw_master_model

/* tb/tb_top.sv */
// Self-checking bench for the diagnostic word block.
`timescale 1ns/10ps
module tb_top;
  import cdsw_pkg::*;
  localparam int LIM = 5;
  logic sys_clk = 0, sys_rst = 1, cycleDone = 0, unitTick = 0;
  logic hoursLoad = 0, reportEnable = 0, interruptEnable = 0, cfgLoad = 0;
  logic usbRead = 0, exSeen = 0, hit, exchangeStart, couplerLed;
  logic moduleFaultIndicator;
  logic [7:0] moduleCount = 8'h01;
  logic [23:0] hoursPreset = 24'h000000;
  logic [15:0] usbData, diagWord, got, w;
  cdsw_cond_t cond = '0;
  cdsw_req_t masterReq;
  cdsw_rsp_t masterRsp;
  int n_fail = 0, tests_run = 0, cyc = 0, svc = 0;
  cdsw_diag_word #(
    .SERVICE_LIMIT(LIM)
  ) u_cdsw_diag_word (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cond(cond),
    .moduleCount(moduleCount),
    .cycleDone(cycleDone),
    .unitTick(unitTick),
    .hoursPreset(hoursPreset),
    .hoursLoad(hoursLoad),
    .reportEnable(reportEnable),
    .interruptEnable(interruptEnable),
    .cfgLoad(cfgLoad),
    .masterReq(masterReq),
    .usbRead(usbRead),
    .masterRsp(masterRsp),
    .usbData(usbData),
    .exchangeStart(exchangeStart),
    .diagWord(diagWord),
    .couplerLed(couplerLed),
    .moduleFaultIndicator(moduleFaultIndicator)
  );
  cdsw_master_model u_cdsw_master_model (
    .sys_clk(sys_clk),
    .masterReq(masterReq),
    .masterRsp(masterRsp)
  );
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (exchangeStart === 1'b1) exSeen = 1;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task capture;
    #1;
    w = {8'h00, cond.couplerError, cond.channelError | cond.fieldPowerError
      | cond.busPowerError, svc != 0, 1'b0, moduleCount == 8'h00,
      cond.busCommError | cond.moduleReplaceError, cond.singlePacket,
      cond.configIncomplete};
    @(posedge sys_clk) cycleDone <= 1;
    @(posedge sys_clk) cycleDone <= 0;
    @(posedge sys_clk) usbRead <= 1;
    @(posedge sys_clk) usbRead <= 0;
    #1;
    chk(diagWord, w);
    chk(usbData, w);
    chk({14'h0, couplerLed, moduleFaultIndicator}, {14'h0, w[7:6]});
  endtask : capture
  task rd(input logic [7:0] f, input logic [15:0] a, input logic e);
    u_cdsw_master_model.read(f, a, hit, got);
    chk({15'h0000, hit}, {15'h0000, e});
    chk(got, e ? w : 16'h0000);
  endtask : rd
  task cfg(input logic r, input logic n);
    @(posedge sys_clk) begin
      reportEnable <= r;
      interruptEnable <= n;
      cfgLoad <= 1;
    end
    @(posedge sys_clk) cfgLoad <= 0;
  endtask : cfg
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'h3FE28722));
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    w = 16'h0000;
    rd(FUNC_READ_INPUT, INPUT_REG_DIAG, 1'b0);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) cfg(1'b1, 1'b0);
      @(posedge sys_clk) begin
        cond <= cdsw_cond_t'(8'($urandom));
        moduleCount <= 8'($urandom % 3);
      end
      capture;
      rd(FUNC_READ_INPUT, INPUT_REG_DIAG, i >= 20);
    end
    chk({15'h0000, exSeen}, 16'h0000);
    $display("word test done");
    rd(8'h03, INPUT_REG_DIAG, 1'b0);
    rd(8'h06, INPUT_REG_DIAG, 1'b0);
    rd(FUNC_READ_INPUT, 16'h07D2, 1'b0);
    $display("map test done");
    @(posedge sys_clk) begin
      cond <= '0;
      hoursPreset <= 24'(LIM);
      hoursLoad <= 1;
    end
    @(posedge sys_clk) hoursLoad <= 0;
    capture;
    @(posedge sys_clk) unitTick <= 1;
    @(posedge sys_clk) unitTick <= 0;
    svc = 1;
    capture;
    $display("service test done");
    cfg(1'b1, 1'b1);
    exSeen = 0;
    @(posedge sys_clk) cond.couplerError <= 1;
    repeat (4) @(posedge sys_clk);
    chk({15'h0000, exSeen}, 16'h0001);
    exSeen = 0;
    @(posedge sys_clk) cond.singlePacket <= 1;
    repeat (4) @(posedge sys_clk);
    chk({15'h0000, exSeen}, 16'h0001);
    $display("interrupt test done");
    @(posedge sys_clk) sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    #1;
    chk(diagWord, DIAG_RESET);
    w = 16'h0000;
    rd(FUNC_READ_INPUT, INPUT_REG_DIAG, 1'b0);
    svc = 0;
    capture;
    $display("reset test done");
    report_and_stop;
  end
endmodule : tb_top
